// *** design/scr_config_regs.sv ***
// scr_config_regs: analog and digital system configuration registers,
// their decoded controls, frame-tail timing, frame sizing and command gating.
// assumes a host register port synchronous to sys_clk, no wait states,
// and frame events from the serial interface as one-cycle pulses.
//
// Notes on behaviour
// - analog bit 7 powers the charge pump
// - analog bit 6: 0 low power, 1 high resolution
// - analog bit 4 picks 2.442 or 4.0 V
// - analog bit 3: external or internal reference
// - analog bits 2:0 select comparator thresholds
// - pump on: low threshold uses pump supply
// - digital bit 7 enables the watchdog counter
// - digital bit 6 picks CRC coverage
// - digital bits 5:4 set completion delay
// - digital bits 3:2 set output release delay
// - digital bit 1 fixes frame word count
// - digital bit 0 appends CRC words
// - failed CRC commands are ignored
// - digital register at 0Ch, resets 3Ch
// - analog register at 0Bh, resets 60h
`timescale 1ns/1ps
module scr_config_regs
   import scr_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // analog controls
   output logic             charge_pump_enable,
   output logic             high_resolution_select,
   output logic             reference_level_select,
   output logic             internal_reference_enable,
   output logic      [2:0]  comparator_threshold_code,
   output logic      [12:0] positive_reference_mv,
   output logic      [9:0]  comp_high_permille,
   output logic      [9:0]  comp_low_permille,
   output logic             comp_low_from_pump,
   // digital controls
   output logic             watchdog_enable,
   output logic             crc_cover_all,
   output logic             crc_enable,
   output logic             fixed_frame,
   output logic      [1:0]  completion_delay_code,
   output logic      [1:0]  output_release_delay_code,
   // frame sizing
   input  wire logic        four_channel_part,
   input  wire logic [3:0]  adc_channel_enable,
   output logic      [2:0]  frame_words,
   // frame tail timing
   input  wire logic        frame_start,
   input  wire logic        frame_last_bit,
   output logic             frame_done,
   output logic             data_out_oe,
   // incoming command gating
   input  wire logic        cmd_valid,
   input  wire logic        cmd_crc_ok,
   output logic             cmd_accept,
   output logic             cmd_crc_reject
);

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   logic [7:0] analog_system_config_q;
   logic [7:0] digital_system_config_q;
   logic [7:0] reg_rdata_q;
   logic [7:0] reg_rdata_d;
   logic       wr_analog;
   logic       wr_digital;

   assign wr_analog  = reg_wr && (reg_addr == ADDR_ANALOG_CFG);
   assign wr_digital = reg_wr && (reg_addr == ADDR_DIGITAL_CFG);

   // every bit is stored as written, the reserved bit included; keeping
   // it at one is left to software
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         analog_system_config_q <= RST_ANALOG_CFG;
      end else if (wr_analog) begin
         analog_system_config_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         digital_system_config_q <= RST_DIGITAL_CFG;
      end else if (wr_digital) begin
         digital_system_config_q <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port: data stand in the cycle after the strobe only
   // unmapped addresses read as zero

   always_comb begin
      reg_rdata_d = RDATA_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_ANALOG_CFG: begin
               reg_rdata_d = analog_system_config_q;
            end
            ADDR_DIGITAL_CFG: begin
               reg_rdata_d = digital_system_config_q;
            end
            default: begin
               reg_rdata_d = RDATA_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata_q <= RDATA_IDLE;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

   assign reg_rdata = reg_rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // analog controls

   logic [2:0] th_code;

   assign th_code                   = analog_system_config_q[A_TH_MSB:A_TH_LSB];
   assign charge_pump_enable        = analog_system_config_q[A_PUMP_BIT];
   assign high_resolution_select    = analog_system_config_q[A_HRES_BIT];
   assign reference_level_select    = analog_system_config_q[A_LEVEL_BIT];
   assign internal_reference_enable = analog_system_config_q[A_INTREF_BIT];
   assign comparator_threshold_code = th_code;

   // the level choice means nothing on an external reference, so report none
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         positive_reference_mv <= REF_NONE_MV;
      end else if (!analog_system_config_q[A_INTREF_BIT]) begin
         positive_reference_mv <= REF_NONE_MV;
      end else if (analog_system_config_q[A_LEVEL_BIT]) begin
         positive_reference_mv <= REF_HIGH_MV;
      end else begin
         positive_reference_mv <= REF_LOW_MV;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         comp_high_permille <= TH_HIGH[0];
         comp_low_permille  <= TH_LOW[0];
      end else begin
         comp_high_permille <= TH_HIGH[th_code];
         comp_low_permille  <= TH_LOW[th_code];
      end
   end

   // the high side always refers to the positive supply
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         comp_low_from_pump <= 1'b0;
      end else begin
         comp_low_from_pump <= analog_system_config_q[A_PUMP_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // digital controls

   logic [1:0] done_code;
   logic [1:0] rel_code;

   assign done_code = digital_system_config_q[D_DONE_MSB:D_DONE_LSB];
   assign rel_code  = digital_system_config_q[D_REL_MSB:D_REL_LSB];

   // clearing the enable does not resynchronise the watchdog; software
   // must follow it with a reset
   assign watchdog_enable           = digital_system_config_q[D_WDOG_BIT];
   assign crc_cover_all             = digital_system_config_q[D_CRCALL_BIT];
   assign crc_enable                = digital_system_config_q[D_CRCEN_BIT];
   assign fixed_frame               = digital_system_config_q[D_FIXED_BIT];
   assign completion_delay_code     = done_code;
   assign output_release_delay_code = rel_code;

   ////////////////////////////////////////////////////////////////////////////
   // frame sizing

   logic [NUM_CHANNELS-1:0] ch_present;
   logic [2:0]              ch_count;
   logic [2:0]              frame_words_d;

   // a two-channel part has no upper channels, whatever their enables say
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_ch
         if (gi < TWO_CH_COUNT) begin : g_low
            assign ch_present[gi] = adc_channel_enable[gi];
         end else begin : g_high
            assign ch_present[gi] = adc_channel_enable[gi] && four_channel_part;
         end
      end
   endgenerate

   always_comb begin
      ch_count = 3'h0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         ch_count = ch_count + {2'h0, ch_present[i]};
      end
   end

   always_comb begin
      if (digital_system_config_q[D_FIXED_BIT]) begin
         frame_words_d = four_channel_part ? FRAME_FIXED_4CH : FRAME_FIXED_2CH;
      end else begin
         frame_words_d = FRAME_STATUS_WORDS + ch_count
                         + {2'h0, digital_system_config_q[D_CRCEN_BIT]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frame_words <= FRAME_STATUS_WORDS;
      end else begin
         frame_words <= frame_words_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame tail timing

   scr_delay_if done_dly ();
   scr_delay_if rel_dly ();

   scr_frame_e frame_state_q;
   scr_frame_e frame_state_d;
   logic       frame_done_q;
   logic       data_out_oe_q;
   logic       tail_start;

   // a last bit counts only inside a frame, and starts both delays at once
   assign tail_start      = frame_last_bit && (frame_state_q == FR_SHIFT);

   // at 10 MHz every code rounds up to one cycle; the table keeps the
   // codes distinct should the clock ever be raised
   assign done_dly.start  = tail_start;
   assign done_dly.cycles = DLY_CYC[done_code];
   assign rel_dly.start   = tail_start;
   assign rel_dly.cycles  = DLY_CYC[rel_code];

   scr_delay_timer u_done_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .dly     (done_dly.timer)
   );

   scr_delay_timer u_release_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .dly     (rel_dly.timer)
   );

   // unless the next frame starts first, the tail lasts until both delays have run out, so neither is cut short
   always_comb begin
      frame_state_d = frame_state_q;
      case (frame_state_q)
         FR_IDLE: begin
            if (frame_start) begin
               frame_state_d = FR_SHIFT;
            end
         end
         FR_SHIFT: begin
            if (frame_last_bit) begin
               frame_state_d = FR_TAIL;
            end
         end
         FR_TAIL: begin
            if (frame_start) begin
               frame_state_d = FR_SHIFT;
            end else if (!done_dly.busy && !rel_dly.busy && !done_dly.start) begin
               frame_state_d = FR_IDLE;
            end
         end
         default: begin
            frame_state_d = FR_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frame_state_q <= FR_IDLE;
      end else begin
         frame_state_q <= frame_state_d;
      end
   end

   // completion stays up until the next frame begins; a start that meets
   // the completion pulse wins, since the new frame has not finished
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frame_done_q <= 1'b0;
      end else if (frame_start) begin
         frame_done_q <= 1'b0;
      end else if (done_dly.done) begin
         frame_done_q <= 1'b1;
      end
   end

   // the output is driven from frame start until the release delay ends
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_out_oe_q <= 1'b0;
      end else if (frame_start) begin
         data_out_oe_q <= 1'b1;
      end else if (rel_dly.done) begin
         data_out_oe_q <= 1'b0;
      end
   end

   assign frame_done  = frame_done_q;
   assign data_out_oe = data_out_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // incoming command gating

   logic cmd_crc_bad;

   // a command with a bad check is dropped and flagged on cmd_crc_reject;
   // cmd_accept stays low for it
   assign cmd_crc_bad    = digital_system_config_q[D_CRCEN_BIT] && !cmd_crc_ok;
   assign cmd_accept     = cmd_valid && !cmd_crc_bad;
   assign cmd_crc_reject = cmd_valid && cmd_crc_bad;

endmodule

// *** design/scr_pkg.sv ***
// scr_pkg: constants shared by the system configuration register bank.
// assumes a single 10 MHz system clock and an 8-bit register port.
package scr_pkg;

   // register addresses and reset values
   localparam logic [7:0] ADDR_ANALOG_CFG  = 8'h0b;
   localparam logic [7:0] ADDR_DIGITAL_CFG = 8'h0c;
   localparam logic [7:0] RST_ANALOG_CFG   = 8'h60;
   localparam logic [7:0] RST_DIGITAL_CFG  = 8'h3c;
   localparam logic [7:0] RDATA_IDLE       = 8'h00;

   // analog configuration field positions
   localparam int A_PUMP_BIT   = 7;
   localparam int A_HRES_BIT   = 6;
   localparam int A_RSVD_BIT   = 5;
   localparam int A_LEVEL_BIT  = 4;
   localparam int A_INTREF_BIT = 3;
   localparam int A_TH_MSB     = 2;
   localparam int A_TH_LSB     = 0;

   // digital configuration field positions
   localparam int D_WDOG_BIT    = 7;
   localparam int D_CRCALL_BIT  = 6;
   localparam int D_DONE_MSB    = 5;
   localparam int D_DONE_LSB    = 4;
   localparam int D_REL_MSB     = 3;
   localparam int D_REL_LSB     = 2;
   localparam int D_FIXED_BIT   = 1;
   localparam int D_CRCEN_BIT   = 0;

   // comparator thresholds in tenths of a percent of the supply span
   localparam logic [9:0] TH_HIGH [8] = '{10'h3b6, 10'h39d, 10'h384, 10'h36b,
                                           10'h352, 10'h320, 10'h2ee, 10'h2bc};
   localparam logic [9:0] TH_LOW  [8] = '{10'h032, 10'h04b, 10'h064, 10'h07d,
                                           10'h096, 10'h0c8, 10'h0fa, 10'h12c};

   // internal positive reference level in millivolts
   localparam logic [12:0] REF_LOW_MV  = 13'h098a;
   localparam logic [12:0] REF_HIGH_MV = 13'h0fa0;
   localparam logic [12:0] REF_NONE_MV = 13'h0000;

   // delay codes in ns, turned into whole clock cycles (least times round up)
   localparam int CLK_PERIOD_NS = 100;
   localparam int DLY_NS [4] = '{6, 8, 10, 12};
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam logic [3:0] DLY_CYC [4] = '{4'(ns_to_cycles(DLY_NS[0])),
                                          4'(ns_to_cycles(DLY_NS[1])),
                                          4'(ns_to_cycles(DLY_NS[2])),
                                          4'(ns_to_cycles(DLY_NS[3]))};

   // frame sizing
   localparam int         NUM_CHANNELS        = 4;
   localparam int         TWO_CH_COUNT        = 2;
   localparam logic [2:0] FRAME_STATUS_WORDS  = 3'h1;
   localparam logic [2:0] FRAME_FIXED_4CH     = 3'h6;
   localparam logic [2:0] FRAME_FIXED_2CH     = 3'h4;

   typedef enum logic [1:0] {
      FR_IDLE,
      FR_SHIFT,
      FR_TAIL
   } scr_frame_e;

endpackage

// *** design/scr_delay_if.sv ***
// scr_delay_if: start, length and completion of one frame-tail delay.
// assumes both ends share sys_clk.
`timescale 1ns/1ps
interface scr_delay_if;
   logic       start;
   logic [3:0] cycles;
   logic       busy;
   logic       done;

   modport ctrl  (output start, output cycles, input busy, input done);
   modport timer (input start, input cycles, output busy, output done);
endinterface

// *** design/scr_delay_timer.sv ***
// scr_delay_timer: counts a loaded number of cycles, then pulses done.
// assumes start is a one-cycle pulse and cycles is at least one.
`timescale 1ns/1ps
module scr_delay_timer
   import scr_pkg::*;
(
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   rst,
   // delay request
   scr_delay_if.timer  dly
);

   logic [3:0] count_q;
   logic       done_q;

   // a new start restarts the count, so back-to-back frames never merge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_q <= 4'h0;
      end else if (dly.start) begin
         count_q <= dly.cycles;
      end else if (count_q != 4'h0) begin
         count_q <= count_q - 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= !dly.start && (count_q == 4'h1);
      end
   end

   assign dly.busy = (count_q != 4'h0);
   assign dly.done = done_q;

endmodule

// *** dv/scr_host.sv ***
// scr_host: host model that reaches the configuration registers over the register port.
// assumes callers enter its tasks just after a rising edge of sys_clk.
`timescale 1ns/1ps
module scr_host
   import scr_pkg::*;
(
   // clock
   input  wire logic       sys_clk,
   // register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // trailing edge keeps two strobes of one kind from sharing a time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == ADDR_ANALOG_CFG) d[A_RSVD_BIT] = 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      q = reg_rdata;
      @(posedge sys_clk);
   endtask
endmodule

// *** dv/scr_config_regs_chk.sv ***
// scr_config_regs_chk: port assertions for the configuration register bank.
// assumes it is bound to scr_config_regs and sees only its ports.
`timescale 1ns/1ps
module scr_config_regs_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // register port
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // analog controls
   input wire logic        charge_pump_enable,
   input wire logic        comp_low_from_pump,
   input wire logic        internal_reference_enable,
   input wire logic        reference_level_select,
   input wire logic [12:0] positive_reference_mv,
   input wire logic [9:0]  comp_high_permille,
   input wire logic [9:0]  comp_low_permille,
   // commands
   input wire logic        crc_enable,
   input wire logic        cmd_valid,
   input wire logic        cmd_crc_ok,
   input wire logic        cmd_accept,
   input wire logic        cmd_crc_reject,
   // frame tail
   input wire logic        frame_start,
   input wire logic        frame_last_bit,
   input wire logic        frame_done,
   input wire logic        data_out_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   pump_low_a: assert property (comp_low_from_pump == $past(charge_pump_enable))
      else $error("low threshold supply wrong");
   ref_level_a: assert property (positive_reference_mv ==
      (!$past(internal_reference_enable) ? 13'h0000 :
       $past(reference_level_select) ? 13'h0fa0 : 13'h098a))
      else $error("reference level wrong");
   th_span_a: assert property ({1'b0, comp_high_permille}
      + {1'b0, comp_low_permille} == 11'h3e8)
      else $error("thresholds not symmetric");
   cmd_reject_a: assert property (cmd_valid && crc_enable && !cmd_crc_ok
      |-> cmd_crc_reject && !cmd_accept)
      else $error("bad command not rejected");
   cmd_take_a: assert property (cmd_valid && !(crc_enable && !cmd_crc_ok)
      |-> cmd_accept && !cmd_crc_reject)
      else $error("good command not accepted");
   oe_start_a: assert property (frame_start |=> data_out_oe && !frame_done)
      else $error("frame start not seen");
   tail_end_a: assert property (frame_last_bit && data_out_oe && !frame_start
      ##1 !frame_start ##1 !frame_start |=> frame_done && !data_out_oe)
      else $error("frame tail timing wrong");
endmodule
bind scr_config_regs scr_config_regs_chk scr_config_regs_chk_i (.sys_clk, .rst, .reg_rd,
   .reg_rdata, .charge_pump_enable, .comp_low_from_pump, .internal_reference_enable,
   .reference_level_select, .positive_reference_mv, .comp_high_permille, .comp_low_permille,
   .crc_enable, .cmd_valid, .cmd_crc_ok, .cmd_accept, .cmd_crc_reject, .frame_start,
   .frame_last_bit, .frame_done, .data_out_oe);

// *** dv/scr_config_regs_bench.sv ***
// scr_config_regs_bench: self-checking bench of the configuration register bank.
// assumes scr_host drives the register port; frame and command inputs are driven here.
`timescale 1ns/1ps
module scr_config_regs_bench
   import scr_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   logic reg_wr, reg_rd, cpe, hrs, rls, ire, lfp, wde, cca, cre, ffr, fdn, doe, acc, rej;
   logic [2:0] ctc, frame_words;
   logic [1:0] cdc, rdc;
   logic [12:0] mv;
   logic [9:0] hi, lo;
   logic four_ch = 1'b0, fst = 1'b0, flb = 1'b0, cmd_valid = 1'b0, cmd_ok = 1'b0;
   logic [3:0] chen = 4'h0;
   logic [31:0] lfsr_q = 32'h02fe;
   int n_fail = 0, tests_run = 0, ana_m, dig_m, exp_w;
   int hi_t [8] = '{950, 925, 900, 875, 850, 800, 750, 700};
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
   always #50 sys_clk = ~sys_clk;
   scr_host scr_host_i (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   scr_config_regs scr_config_regs_i (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .charge_pump_enable(cpe), .high_resolution_select(hrs),
      .reference_level_select(rls), .internal_reference_enable(ire),
      .comparator_threshold_code(ctc), .positive_reference_mv(mv), .comp_high_permille(hi),
      .comp_low_permille(lo), .comp_low_from_pump(lfp), .watchdog_enable(wde),
      .crc_cover_all(cca), .crc_enable(cre), .fixed_frame(ffr), .completion_delay_code(cdc),
      .output_release_delay_code(rdc), .four_channel_part(four_ch),
      .adc_channel_enable(chen), .frame_words, .frame_start(fst), .frame_last_bit(flb),
      .frame_done(fdn), .data_out_oe(doe), .cmd_valid, .cmd_crc_ok(cmd_ok),
      .cmd_accept(acc), .cmd_crc_reject(rej));
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic do_reset();
      rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      ana_m = 'h60;
      dig_m = 'h3c;
   endtask
   task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
      scr_host_i.wr(a, d);
      if (a == ADDR_ANALOG_CFG) ana_m = d | 8'h20;
      if (a == ADDR_DIGITAL_CFG) dig_m = d;
   endtask
   // readback plus every decoded control against the model
   task automatic check_regs();
      scr_host_i.rd(8'h0b, q);
      `CHECK(q, ana_m)
      scr_host_i.rd(8'h0c, q);
      `CHECK(q, dig_m)
      `CHECK({cpe, hrs, rls, ire, ctc}, {ana_m[7:6], ana_m[4:0]})
      `CHECK({wde, cca, cdc, rdc, ffr, cre}, dig_m)
      `CHECK(hi, hi_t[ana_m[2:0]])
      `CHECK(lo, 1000 - hi_t[ana_m[2:0]])
      `CHECK(lfp, ana_m[7])
      `CHECK(mv, ana_m[3] ? (ana_m[4] ? 4000 : 2442) : 0)
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      check_regs();
      wr_m(8'h0d, 8'hff);
      scr_host_i.rd(8'h0d, q);
      `CHECK(q, 0)
      check_regs();
      $display("test reset and unmapped done");
      for (int i = 0; i < 16; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         wr_m(8'h0b, (i < 8) ? 8'((i << 5) | (i << 3) | i) : lfsr_q[7:0]);
         wr_m(8'h0c, lfsr_q[15:8]);
         check_regs();
      end
      $display("test field codes done");
      for (int k = 0; k < 128; k++) begin
         wr_m(8'h0c, 8'h3c | 8'(k & 3));
         four_ch <= k[2];
         chen <= 4'(k >> 3);
         @(posedge sys_clk);
         @(negedge sys_clk);
         exp_w = 1 + k[0] + k[3] + k[4] + (k[2] ? k[5] + k[6] : 0);
         `CHECK(frame_words, k[1] ? (k[2] ? 6 : 4) : exp_w)
         @(posedge sys_clk);
      end
      $display("test frame size done");
      for (int c = 0; c < 4; c++) begin
         wr_m(8'h0c, 8'((c << 4) | (c << 2)));
         fst <= 1'b1;
         @(posedge sys_clk);
         fst <= 1'b0;
         @(negedge sys_clk);
         `CHECK({doe, fdn}, 2'b10)
         @(posedge sys_clk);
         flb <= 1'b1;
         @(posedge sys_clk);
         flb <= 1'b0;
         @(negedge sys_clk);
         `CHECK({doe, fdn}, 2'b10)
         @(posedge sys_clk);
         @(negedge sys_clk);
         `CHECK({doe, fdn}, 2'b10)
         @(posedge sys_clk);
         @(negedge sys_clk);
         `CHECK({doe, fdn}, 2'b01)
         @(posedge sys_clk);
         flb <= 1'b1;
         @(posedge sys_clk);
         flb <= 1'b0;
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         `CHECK({doe, fdn}, 2'b01)
         @(posedge sys_clk);
      end
      $display("test frame tail done");
      for (int k = 0; k < 4; k++) begin
         wr_m(8'h0c, 8'(k & 1));
         cmd_valid <= 1'b1;
         cmd_ok <= k[1];
         @(negedge sys_clk);
         `CHECK({acc, rej}, (k == 1) ? 2'b01 : 2'b10)
         @(posedge sys_clk);
         cmd_valid <= 1'b0;
      end
      $display("test command gating done");
      wr_m(8'h0c, 8'hbc);
      check_regs();
      wr_m(8'h0c, 8'h3c);
      do_reset();
      check_regs();
      $display("test watchdog and reset done");
      give_verdict();
   end
   initial begin
      #2_000_000;
      n_fail++;
      give_verdict();
   end
endmodule
